/* File: rtl/aom_top.sv */
/*
  Auxiliary output mixer control registers on APB, plus the audio serial
  port clocking and a record FIFO feeding the serial data output.
  Assumes pins are synchronous to pclk and the host keeps reserved bits 0.
*/
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`include "aom_defines.svh"

// ================================================
// Record sample FIFO
module aom_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } aom_fifo_type;
  aom_fifo_type f_r;
  aom_fifo_type f_nxt;
  logic push;
  logic pop;

  always_comb begin
    f_nxt = f_r;
    push = in_valid && f_r.rdy;
    pop = out_ready && (f_r.cnt != '0);
    if (push) begin
      f_nxt.mem[f_r.wp] = in_data;
      f_nxt.wp = f_r.wp + 1'b1;
    end
    if (pop) begin
      f_nxt.rp = f_r.rp + 1'b1;
    end
    f_nxt.cnt = f_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // Registered so the source sees an honest full flag from a flop
    f_nxt.rdy = f_nxt.cnt != (AW+1)'(DEPTH);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  assign in_ready = f_r.rdy;
  assign out_data = f_r.mem[f_r.rp];
  assign out_valid = f_r.cnt != '0;
  assign level = f_r.cnt;
endmodule : aom_fifo

// How it works
// - Left mixer has four source enable bits
// - Aux A enable aliased in power register
// - Right mixer has five source enable bits
// - Bit 10 halves the aux B level
// - Right mixer bit 2 unsupported, reads 0
// - Aux B enable aliased in power register
// - All mixer bits reset to zero
// - Serial port independent, four dedicated pins
// - Master drives clocks, slave receives them
// - Record clocks on gpio5 and gpio6/8
module aom_top import aom_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic [3:0] aux_a_sources,
  output logic aux_a_enable,
  output logic [4:0] aux_b_sources,
  output logic aux_b_half_level,
  output logic aux_b_enable,
  input wire logic [15:0] rec_data,
  input wire logic rec_valid,
  output logic rec_ready,
  output logic record_serial_out,
  input wire logic playback_serial_in,
  output logic [15:0] play_data,
  output logic play_valid,
  output logic play_right,
  input wire logic word_clock_i,
  output logic word_clock_o,
  output logic word_clock_oe,
  input wire logic bit_clock_i,
  output logic bit_clock_o,
  output logic bit_clock_oe,
  input wire logic gpio5_i,
  output logic gpio5_o,
  output logic gpio5_oe,
  input wire logic gpio6_i,
  output logic gpio6_o,
  output logic gpio6_oe,
  input wire logic gpio8_i,
  output logic gpio8_o,
  output logic gpio8_oe
);
  aom_state_type st_r;
  aom_state_type st_nxt;
  logic [15:0] fifo_data;
  logic fifo_valid;
  logic fifo_take;
  logic [5:0] fifo_level;
  logic [9:0] idx;
  logic aligned;
  logic wr_go;
  logic [15:0] wv;
  logic dac_bc, dac_lr, adc_bc, adc_lr;

  assign idx = paddr[11:2];
  assign aligned = paddr[1:0] == 2'b00;
  assign wr_go = psel && penable && pwrite && st_r.pready;

  // ================================================
  // Clock source selection per side
  always_comb begin
    dac_bc = st_r.aif[`AOM_AIF_DAC_MST] ? st_r.gen_bc : bit_clock_i;
    dac_lr = st_r.aif[`AOM_AIF_DAC_MST] ? st_r.gen_lr : word_clock_i;
    adc_bc = dac_bc;
    adc_lr = dac_lr;
    if (st_r.aif[`AOM_AIF_SPLIT]) begin
      adc_lr = st_r.aif[`AOM_AIF_ADC_MST] ? st_r.gen_lr : gpio5_i;
      adc_bc = st_r.aif[`AOM_AIF_ADC_MST] ? st_r.gen_bc :
               (st_r.aif[`AOM_AIF_GPIO8] ? gpio8_i : gpio6_i);
    end
  end

  aom_fifo #(.W(16), .DEPTH(32)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_data(rec_data),
    .in_valid(rec_valid),
    .in_ready(rec_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .level(fifo_level)
  );

  // ================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    fifo_take = 1'b0;
    // Byte lanes not strobed keep the value read during setup
    wv = {pstrb[1] ? pwdata[15:8] : st_r.prdata[15:8],
          pstrb[0] ? pwdata[7:0] : st_r.prdata[7:0]};

    // APB: decode at setup, answer in the first access cycle
    st_nxt.pready = psel && !penable;
    st_nxt.pslverr = 1'b0;
    if (psel && !penable) begin
      st_nxt.prdata = 32'h0000_0000;
      st_nxt.pslverr = !aligned;
      if (aligned) begin
        unique case (idx)
          `AOM_IDX_PWR2: begin
            st_nxt.prdata[`AOM_PWR_A_EN] = st_r.a_en;
            st_nxt.prdata[`AOM_PWR_B_EN] = st_r.b_en;
          end
          `AOM_IDX_AUXL: begin
            st_nxt.prdata[`AOM_MIX_EN] = st_r.a_en;
            st_nxt.prdata[`AOM_L_DAC] = st_r.a_src[3];
            st_nxt.prdata[`AOM_L_MIXIN] = st_r.a_src[2];
            st_nxt.prdata[`AOM_L_BMIX] = st_r.a_src[1];
            st_nxt.prdata[`AOM_L_MIXOUT] = st_r.a_src[0];
          end
          `AOM_IDX_AUXR: begin
            // Bit 2 stays zero: that path does nothing
            st_nxt.prdata[`AOM_MIX_EN] = st_r.b_en;
            st_nxt.prdata[`AOM_R_DACR] = st_r.b_src[4];
            st_nxt.prdata[`AOM_R_DACL] = st_r.b_src[3];
            st_nxt.prdata[`AOM_R_ATT] = st_r.b_att;
            st_nxt.prdata[`AOM_R_MIXIN] = st_r.b_src[2];
            st_nxt.prdata[`AOM_R_MIXOUTR] = st_r.b_src[1];
            st_nxt.prdata[`AOM_R_MIXOUTL] = st_r.b_src[0];
          end
          `AOM_IDX_AIF: st_nxt.prdata[3:0] = st_r.aif;
          `AOM_IDX_STAT: st_nxt.prdata[5:0] = fifo_level;
          default: st_nxt.pslverr = 1'b1;
        endcase
      end
    end

    if (wr_go && aligned) begin
      if (idx == `AOM_IDX_PWR2) begin
        st_nxt.a_en = wv[`AOM_PWR_A_EN];
        st_nxt.b_en = wv[`AOM_PWR_B_EN];
      end
      if (idx == `AOM_IDX_AUXL) begin
        st_nxt.a_en = wv[`AOM_MIX_EN];
        st_nxt.a_src = {wv[`AOM_L_DAC], wv[`AOM_L_MIXIN],
                        wv[`AOM_L_BMIX], wv[`AOM_L_MIXOUT]};
      end
      if (idx == `AOM_IDX_AUXR) begin
        st_nxt.b_en = wv[`AOM_MIX_EN];
        st_nxt.b_att = wv[`AOM_R_ATT];
        st_nxt.b_src = {wv[`AOM_R_DACR], wv[`AOM_R_DACL], wv[`AOM_R_MIXIN],
                        wv[`AOM_R_MIXOUTR], wv[`AOM_R_MIXOUTL]};
      end
      if (idx == `AOM_IDX_AIF) begin
        st_nxt.aif = wv[3:0];
      end
    end

    // ================================================
    // Master clock generator: word clock turns on a falling bit clock
    if (st_r.div == 3'(`AOM_BCLK_HALF - 1)) begin
      st_nxt.div = 3'h0;
      st_nxt.gen_bc = !st_r.gen_bc;
      if (st_r.gen_bc) begin
        st_nxt.gen_bits = st_r.gen_bits + 4'h1;
        if (st_r.gen_bits == 4'(`AOM_SLOT_BITS - 1)) begin
          st_nxt.gen_lr = !st_r.gen_lr;
        end
      end
    end else begin
      st_nxt.div = st_r.div + 3'h1;
    end

    // Pin drivers follow the master bits one cycle late
    st_nxt.clk_oe = st_r.aif[`AOM_AIF_DAC_MST];
    st_nxt.g5_oe = st_r.aif[`AOM_AIF_SPLIT] && st_r.aif[`AOM_AIF_ADC_MST];
    st_nxt.g6_oe = st_nxt.g5_oe && !st_r.aif[`AOM_AIF_GPIO8];
    st_nxt.g8_oe = st_nxt.g5_oe && st_r.aif[`AOM_AIF_GPIO8];

    st_nxt.dac_bc_q = dac_bc;
    st_nxt.dac_lr_q = dac_lr;
    st_nxt.adc_bc_q = adc_bc;
    st_nxt.adc_lr_q = adc_lr;

    // ================================================
    // Record path: MSB first, loaded at each word clock edge
    if (adc_lr != st_r.adc_lr_q) begin
      // An empty FIFO sends a silent word rather than stalling the frame
      fifo_take = fifo_valid;
      st_nxt.tx_sh = fifo_valid ? fifo_data : 16'h0000;
      st_nxt.rec_out = fifo_valid && fifo_data[15];
    end else if (st_r.adc_bc_q && !adc_bc) begin
      st_nxt.tx_sh = {st_r.tx_sh[14:0], 1'b0};
      st_nxt.rec_out = st_r.tx_sh[14];
    end

    // Playback path: bits taken on rising bit clock
    st_nxt.play_valid = 1'b0;
    if (dac_lr != st_r.dac_lr_q) begin
      st_nxt.rx_cnt = 5'h00;
    end else if (!st_r.dac_bc_q && dac_bc && st_r.rx_cnt != 5'(`AOM_SLOT_BITS)) begin
      st_nxt.rx_sh = {st_r.rx_sh[14:0], playback_serial_in};
      st_nxt.rx_cnt = st_r.rx_cnt + 5'h01;
      if (st_r.rx_cnt == 5'(`AOM_SLOT_BITS - 1)) begin
        st_nxt.play_data = st_nxt.rx_sh;
        st_nxt.play_valid = 1'b1;
        st_nxt.play_right = dac_lr;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ================================================
  // Outputs
  assign pready = st_r.pready;
  assign prdata = st_r.prdata;
  assign pslverr = st_r.pslverr;
  assign aux_a_sources = st_r.a_src;
  assign aux_a_enable = st_r.a_en;
  assign aux_b_sources = st_r.b_src;
  assign aux_b_half_level = st_r.b_att;
  assign aux_b_enable = st_r.b_en;
  assign record_serial_out = st_r.rec_out;
  assign play_data = st_r.play_data;
  assign play_valid = st_r.play_valid;
  assign play_right = st_r.play_right;
  assign word_clock_o = st_r.gen_lr;
  assign word_clock_oe = st_r.clk_oe;
  assign bit_clock_o = st_r.gen_bc;
  assign bit_clock_oe = st_r.clk_oe;
  assign gpio5_o = st_r.gen_lr;
  assign gpio5_oe = st_r.g5_oe;
  assign gpio6_o = st_r.gen_bc;
  assign gpio6_oe = st_r.g6_oe;
  assign gpio8_o = st_r.gen_bc;
  assign gpio8_oe = st_r.g8_oe;

  // ================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wr(logic [9:0] i);
    wr_go && aligned && idx == i && pstrb[1:0] == 2'b11;
  endsequence

  sequence s_rd(logic [9:0] i);
    psel && !penable && !pwrite && aligned && idx == i;
  endsequence

  AST_LEFT_SRC: assert property (s_wr(`AOM_IDX_AUXL) |=>
    aux_a_sources == {$past(pwdata[11]), $past(pwdata[8]), $past(pwdata[3]),
                      $past(pwdata[0])}) else $error("left mixer sources wrong");
  AST_ALIAS_A: assert property (s_wr(`AOM_IDX_PWR2) ##2 s_rd(`AOM_IDX_AUXL)
    |=> prdata[15] == $past(pwdata[4], 3)) else $error("aux a alias mismatch");
  AST_RIGHT_SRC: assert property (s_wr(`AOM_IDX_AUXR) |=>
    aux_b_sources == {$past(pwdata[12]), $past(pwdata[11]), $past(pwdata[9]),
                      $past(pwdata[1]), $past(pwdata[0])}) else $error("right sources wrong");
  AST_HALF_LEVEL: assert property (s_wr(`AOM_IDX_AUXR) |=>
    aux_b_half_level == $past(pwdata[10])) else $error("half level not stored");
  AST_BIT2_ZERO: assert property (s_rd(`AOM_IDX_AUXR) |=> !prdata[2])
    else $error("unsupported bit reads one");
  AST_ALIAS_B: assert property (s_wr(`AOM_IDX_AUXR) ##2 s_rd(`AOM_IDX_PWR2)
    |=> prdata[5] == $past(pwdata[15], 3)) else $error("aux b alias mismatch");
  AST_RESET_ZERO: assert property ($rose(presetn) |->
    aux_a_sources == 4'h0 && aux_b_sources == 5'h00 && !aux_a_enable &&
    !aux_b_enable && !aux_b_half_level) else $error("mixer bits not zero after reset");
  AST_MASTER_OE: assert property ($stable(st_r.aif) [*2] |->
    bit_clock_oe == st_r.aif[0] && word_clock_oe == st_r.aif[0])
    else $error("clock pin direction wrong");
  AST_REC_LOAD: assert property ((adc_lr != st_r.adc_lr_q) && fifo_valid |=>
    record_serial_out == $past(fifo_data[15])) else $error("record msb not sent");
  AST_GPIO5: assert property ($stable(st_r.aif) [*2] |->
    gpio5_oe == (st_r.aif[2] && st_r.aif[1])) else $error("gpio5 direction wrong");
endmodule : aom_top

/* File: pkg/aom_defines.svh */
/*
  Offsets, field positions, reset values and timing counts for the
  auxiliary output mixer control block. Assumes APB with word addressing.
*/
`ifndef AOM_DEFINES_SVH
`define AOM_DEFINES_SVH
// ================================================
// Register indices (byte address is index times four)
`define AOM_IDX_PWR2 10'h009
`define AOM_IDX_AUXL 10'h05C
`define AOM_IDX_AUXR 10'h05D
`define AOM_IDX_AIF 10'h07E
`define AOM_IDX_STAT 10'h07F
// ================================================
// Field positions
`define AOM_PWR_A_EN 4
`define AOM_PWR_B_EN 5
`define AOM_MIX_EN 15
`define AOM_L_DAC 11
`define AOM_L_MIXIN 8
`define AOM_L_BMIX 3
`define AOM_L_MIXOUT 0
`define AOM_R_DACR 12
`define AOM_R_DACL 11
`define AOM_R_ATT 10
`define AOM_R_MIXIN 9
`define AOM_R_MIXOUTR 1
`define AOM_R_MIXOUTL 0
`define AOM_AIF_DAC_MST 0
`define AOM_AIF_ADC_MST 1
`define AOM_AIF_SPLIT 2
`define AOM_AIF_GPIO8 3
// ================================================
// Reset values
`define AOM_RST_A_SRC 4'h0
`define AOM_RST_B_SRC 5'h00
`define AOM_RST_AIF 4'h0
// ================================================
// Timing: clock 25 MHz, bit clock half period in pclk cycles
`define AOM_PCLK_MHZ 25
`define AOM_BCLK_MHZ_X8 25
`define AOM_BCLK_HALF (`AOM_PCLK_MHZ * 4 / `AOM_BCLK_MHZ_X8)
`define AOM_SLOT_BITS 16
`endif

/* File: pkg/aom_pkg.sv */
/*
  Types of the auxiliary output mixer control block.
  Assumes aom_defines.svh is included before use.
*/
package aom_pkg;
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [3:0] a_src;
    logic a_en;
    logic [4:0] b_src;
    logic b_att;
    logic b_en;
    logic [3:0] aif;
    logic [2:0] div;
    logic gen_bc;
    logic gen_lr;
    logic [3:0] gen_bits;
    logic dac_bc_q;
    logic dac_lr_q;
    logic adc_bc_q;
    logic adc_lr_q;
    logic [15:0] tx_sh;
    logic rec_out;
    logic [15:0] rx_sh;
    logic [4:0] rx_cnt;
    logic [15:0] play_data;
    logic play_valid;
    logic play_right;
    logic clk_oe;
    logic g5_oe;
    logic g6_oe;
    logic g8_oe;
  } aom_state_type;
endpackage : aom_pkg

/* File: verif/aom_host_port.sv */
/*
  Host side of the audio serial port in slave operation: makes the word
  and bit clocks and sends one playback word for each go pulse.
  Assumes go is a one-cycle pulse given only while the model is idle.
*/
`timescale 1ns/100ps
// ================================================
// Host serial port model
module aom_host_port (
  input wire logic pclk,
  input wire logic go,
  input wire logic [3:0] half,
  input wire logic [15:0] word,
  output logic word_clk,
  output logic bit_clk,
  output logic sdata
);
  int n;
  initial begin
    word_clk = 1'b0;
    bit_clk = 1'b0;
    sdata = 1'b0;
    forever begin
      @(posedge pclk);
      if (go) begin
        // Bit clock runs only within a word and stands low between words; word clock toggles once per word
        word_clk <= ~word_clk;
        for (n = 15; n >= 0; n--) begin
          sdata <= word[n];
          repeat (half) @(posedge pclk);
          bit_clk <= 1'b1;
          repeat (half) @(posedge pclk);
          bit_clk <= 1'b0;
        end
      end else begin
        // Toggle when idle so a stale bit never passes for data
        sdata <= ~sdata;
      end
    end
  end
endmodule : aom_host_port

/* File: verif/aom_top_tb.sv */
/*
  Self-checking bench for aom_top: mixer registers over APB, pin roles,
  playback words, record FIFO and serial output.
  Assumes aom_host_port stands in for the host serial port.
*/
`timescale 1ns/100ps
`include "aom_defines.svh"
module aom_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] a_src, half;
  logic [4:0] b_src;
  logic a_en, b_half, b_en, rec_valid, rec_ready, rso, play_valid, play_right;
  logic [15:0] rec_data, play_data, hw, dl, dr, sh;
  logic [1:0] pw2;
  logic psi, wco, wcoe, bco, bcoe, hwc, hbc, wci, bci, wexp, pw;
  logic g5o, g5oe, g6o, g6oe, g8o, g8oe;
  logic [3:0] aifv[4] = '{4'h1, 4'h6, 4'hE, 4'h0};
  logic [4:0] oev[4] = '{5'h18, 5'h06, 5'h05, 5'h00};
  logic [15:0] fq[$];
  int failures, n_compared, seed, i, k;
  localparam logic [11:0] A_P = {`AOM_IDX_PWR2, 2'b00};
  localparam logic [11:0] A_L = {`AOM_IDX_AUXL, 2'b00};
  localparam logic [11:0] A_R = {`AOM_IDX_AUXR, 2'b00};
  localparam logic [11:0] A_I = {`AOM_IDX_AIF, 2'b00};
  localparam logic [11:0] A_S = {`AOM_IDX_STAT, 2'b00};
  // Shared clock wires: whoever has the enable drives them
  assign wci = wcoe ? wco : hwc;
  assign bci = bcoe ? bco : hbc;

  aom_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .aux_a_sources(a_src), .aux_a_enable(a_en),
    .aux_b_sources(b_src), .aux_b_half_level(b_half), .aux_b_enable(b_en),
    .rec_data(rec_data), .rec_valid(rec_valid), .rec_ready(rec_ready),
    .record_serial_out(rso), .playback_serial_in(psi), .play_data(play_data),
    .play_valid(play_valid), .play_right(play_right), .word_clock_i(wci),
    .word_clock_o(wco), .word_clock_oe(wcoe), .bit_clock_i(bci), .bit_clock_o(bco),
    .bit_clock_oe(bcoe), .gpio5_i(hwc), .gpio5_o(g5o), .gpio5_oe(g5oe),
    .gpio6_i(hbc), .gpio6_o(g6o), .gpio6_oe(g6oe), .gpio8_i(1'b0), .gpio8_o(g8o),
    .gpio8_oe(g8oe));
  aom_host_port host (.pclk(pclk), .go(go), .half(half), .word(hw),
    .word_clk(hwc), .bit_clk(hbc), .sdata(psi));

  // ================================================
  // Checking and bus tasks
  function automatic logic [15:0] rmask(input logic [15:0] d, input logic r);
    return d & (r ? 16'h9E03 : 16'h8909);
  endfunction : rmask
  function automatic logic [11:0] xout(input logic [15:0] l, input logic [15:0] r);
    return {l[15], l[11], l[8], l[3], l[0], r[15], r[10], r[12], r[11], r[9], r[1], r[0]};
  endfunction : xout
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic close_out();
    if (failures == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  task automatic guard(input logic bad);
    if (bad) begin
      failures++;
      close_out();
    end
  endtask : guard
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    guard(pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk("write error", 0, e);
  endtask : wr
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] m,
                    input logic [31:0] x);
    apb(1'b0, a, 0);
    chk(nm, x & m, q & m);
    chk("read error", 0, e);
  endtask : rd
  // Shifts in 16 record bits at rising edges of the host or the device bit clock
  task automatic grab(input logic h, output logic [15:0] w);
    logic c, p;
    int m, j;
    p = h ? hbc : bco;
    m = 0;
    for (j = 0; j < 400 && m < 16; j++) begin
      @(posedge pclk);
      c = h ? hbc : bco;
      if (c === 1'b1 && p === 1'b0) begin
        w = {w[14:0], rso};
        m++;
      end
      p = c;
    end
    guard(m < 16);
  endtask : grab

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ================================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, rec_valid, go, wexp} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    rec_data = 16'h0000;
    half = 4'h4;
    seed = 6;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("reset outs", 0, {a_en, a_src, b_en, b_half, b_src,
                          wcoe, bcoe, g5oe, g6oe, g8oe});
    rd("left", A_L, 32'hFFFF, 0);
    rd("right", A_R, 32'hFFFF, 0);
    rd("pwr", A_P, 32'h30, 0);
    for (i = 0; i < 16; i++) begin
      dl = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h8000 : 16'($random(seed));
      dr = (i == 0) ? 16'hFFFF : (i == 2) ? 16'h9E00 : 16'($random(seed));
      wr(A_L, {16'h0, dl});
      wr(A_R, {16'h0, dr});
      @(negedge pclk);
      chk("mixer outs", xout(dl, dr), {a_en, a_src, b_en, b_half, b_src});
      rd("pwr", A_P, 32'h30, {dr[15], dl[15], 4'h0});
      rd("left", A_L, 32'hFFFFFFFF, rmask(dl, 0));
      rd("right", A_R, 32'hFFFFFFFF, rmask(dr, 1));
      pw2 = 2'($random(seed));
      wr(A_P, {26'h0, pw2, 4'h0});
      rd("left en", A_L, 32'h8000, {pw2[0], 15'h0});
      rd("right en", A_R, 32'h8000, {pw2[1], 15'h0});
      @(negedge pclk);
      chk("enables", pw2, {b_en, a_en});
    end
    apb(1'b0, 12'h100, 0);
    chk("unmapped error", 1, e);
    chk("unmapped data", 0, q);
    apb(1'b1, A_L + 12'h001, 32'hFFFF);
    chk("misaligned error", 1, e);
    rd("left kept", A_L, 32'h7FFF, rmask(dl, 0));
    wr(A_S, 32'h3F);
    for (i = 0; i < 4; i++) begin
      wr(A_I, {28'h0, aifv[i]});
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk("pin roles", oev[i], {wcoe, bcoe, g5oe, g6oe, g8oe});
      chk("gpio clocks", {wco, bco, bco}, {g5o, g6o, g8o});
    end
    for (i = 0; i < 4; i++) begin
      hw = 16'($random(seed));
      half <= i[0] ? 4'h7 : 4'h4;
      wexp = ~wexp;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (play_valid !== 1'b1 && k < 400);
      guard(play_valid !== 1'b1);
      chk("play word", hw, play_data);
      chk("play side", wexp, play_right);
      repeat (16) @(posedge pclk);
    end
    // Record clocks idle in slave mode, so nothing drains while filling
    rec_valid <= 1'b1;
    rec_data <= 16'($random(seed));
    for (k = 0; k < 40; k++) begin
      @(posedge pclk);
      if (rec_ready === 1'b1) begin
        fq.push_back(rec_data);
        rec_data <= 16'($random(seed));
      end
    end
    rec_valid <= 1'b0;
    chk("fifo depth", 32, fq.size());
    rd("level", A_S, 32'h3F, 32'h20);
    // Record clocks taken from the host on the gpio pins
    wr(A_I, 32'h4);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    grab(1'b1, sh);
    chk("gpio record word", fq.pop_front(), sh);
    // Hand over to the generator while its word clock matches the host's, so no false edge
    for (k = 0; k < 400 && wco === hwc; k++) @(posedge pclk);
    for (k = 0; k < 400 && wco !== hwc; k++) @(posedge pclk);
    guard(wco !== hwc);
    wr(A_I, 32'h1);
    pw = wco;
    for (k = 0; k < 400 && wco === pw; k++) @(posedge pclk);
    guard(wco === pw);
    grab(1'b0, sh);
    chk("record word", fq[0], sh);
    for (i = 0; i < 60; i++) begin
      repeat (100) @(posedge pclk);
      apb(1'b0, A_S, 0);
      if (q[5:0] === 6'h00) break;
    end
    chk("drained level", 0, q[5:0]);
    chk("ready again", 1, rec_ready);
    close_out();
  end
endmodule : aom_top_tb
